// [logic/ipcb_pkg.sv]
// Package: register map, field layout and reset values of the priority bank
package ipcb_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int PRIO_W = 3;
   localparam int NUM_REGS = 5;
   localparam int NUM_SRC = 18;
   // Register indices (word offsets)
   localparam logic [3:0] REG_PRIO0 = 4'h0;
   localparam logic [3:0] REG_PRIO1 = 4'h1;
   localparam logic [3:0] REG_PRIO2 = 4'h2;
   localparam logic [3:0] REG_PRIO3 = 4'h3;
   localparam logic [3:0] REG_PRIO4 = 4'h4;
   // Field low-bit positions
   localparam int FLD_HI = 12;
   localparam int FLD_MH = 8;
   localparam int FLD_ML = 4;
   localparam int FLD_LO = 0;
   // Level encoding
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam logic [2:0] PRIO_MIN = 3'h1;
   localparam logic [2:0] PRIO_MAX = 3'h7;
   localparam logic [2:0] PRIO_RESET = 3'h4;
   // Implemented-bit masks per register
   localparam logic [15:0] MASK_FULL = 16'h7777;
   localparam logic [15:0] MASK_PRIO3 = 16'h0777;
   localparam logic [15:0] MASK_PRIO4 = 16'h7077;
   // Reset values (each field 100b)
   localparam logic [15:0] RST_FULL = 16'h4444;
   localparam logic [15:0] RST_PRIO3 = 16'h0444;
   localparam logic [15:0] RST_PRIO4 = 16'h4044;
endpackage

// [logic/ipcb_gate.sv]
// Request gate: blocks a source whose priority is zero
`timescale 1ns/1ps
`default_nettype none
module ipcb_gate #(
   parameter int N = 18
) (
   input wire logic [N-1:0] flag_in,
   input wire logic [3*N-1:0] prio_in,
   output logic [N-1:0] req_out
);
   always_comb begin
      for (int i = 0; i < N; i++) begin
         req_out[i] = flag_in[i] && (prio_in[3*i +: 3] != ipcb_pkg::PRIO_OFF);
      end
   end
endmodule
`default_nettype wire

// [logic/ipcb_bank.sv]
// Interrupt priority bank: five priority registers, field outputs and request gating
// Contract
// - Three-bit field value is the priority level, 1 lowest through 7 highest.
// - A zero field disables its source; no request regardless of flag.
// - Bits outside priority fields read zero and ignore writes.
// - Register 0: timer1 14-12, outcmp1 10-8, incap1 6-4, ext irq0 2-0.
// - Register 2: uart1 rx, spi1 event, spi1 error, timer3 from top down.
// - Register 3: bits 15-11 unused; dma1 10-8, adc1 6-4, uart1 tx 2-0.
`timescale 1ns/1ps
`default_nettype none
module ipcb_bank (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [ipcb_pkg::ADDR_W-1:0] addr_in,
   input wire logic [ipcb_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [ipcb_pkg::DATA_W-1:0] rdata_out,
   input wire logic [ipcb_pkg::NUM_SRC-1:0] flag_in,
   output logic [ipcb_pkg::NUM_SRC-1:0] req_out,
   output logic [2:0] timer1_prio_out,
   output logic [2:0] outcmp1_prio_out,
   output logic [2:0] incap1_prio_out,
   output logic [2:0] ext_irq0_prio_out,
   output logic [2:0] timer2_prio_out,
   output logic [2:0] outcmp2_prio_out,
   output logic [2:0] incap2_prio_out,
   output logic [2:0] dmach0_done_prio_out,
   output logic [2:0] uart1_rx_prio_out,
   output logic [2:0] spi1_event_prio_out,
   output logic [2:0] spi1_error_prio_out,
   output logic [2:0] timer3_prio_out,
   output logic [2:0] dmach1_done_prio_out,
   output logic [2:0] adc1_done_prio_out,
   output logic [2:0] uart1_tx_prio_out,
   output logic [2:0] change_notify_prio_out,
   output logic [2:0] i2c1_master_prio_out,
   output logic [2:0] i2c1_slave_prio_out
);
   logic [15:0] prio0_q;
   logic [15:0] prio1_q;
   logic [15:0] prio2_q;
   logic [15:0] prio3_q;
   logic [15:0] prio4_q;
   logic [15:0] rdata_q;
   logic [3*ipcb_pkg::NUM_SRC-1:0] prio_vec;

   // Implemented-bit mask of a register index; unmapped indices have none
   function automatic logic [15:0] reg_mask(input logic [3:0] idx);
      unique case (idx)
         ipcb_pkg::REG_PRIO0, ipcb_pkg::REG_PRIO1, ipcb_pkg::REG_PRIO2: reg_mask = ipcb_pkg::MASK_FULL;
         ipcb_pkg::REG_PRIO3: reg_mask = ipcb_pkg::MASK_PRIO3;
         ipcb_pkg::REG_PRIO4: reg_mask = ipcb_pkg::MASK_PRIO4;
         default: reg_mask = 16'h0000;
      endcase
   endfunction

   function automatic logic hit(input logic [3:0] idx);
      hit = wr_in && (addr_in == idx);
   endfunction

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prio0_q <= ipcb_pkg::RST_FULL;
      end else if (hit(ipcb_pkg::REG_PRIO0)) begin
         prio0_q <= wdata_in & ipcb_pkg::MASK_FULL;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prio1_q <= ipcb_pkg::RST_FULL;
      end else if (hit(ipcb_pkg::REG_PRIO1)) begin
         prio1_q <= wdata_in & ipcb_pkg::MASK_FULL;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prio2_q <= ipcb_pkg::RST_FULL;
      end else if (hit(ipcb_pkg::REG_PRIO2)) begin
         prio2_q <= wdata_in & ipcb_pkg::MASK_FULL;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prio3_q <= ipcb_pkg::RST_PRIO3;
      end else if (hit(ipcb_pkg::REG_PRIO3)) begin
         prio3_q <= wdata_in & ipcb_pkg::MASK_PRIO3;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prio4_q <= ipcb_pkg::RST_PRIO4;
      end else if (hit(ipcb_pkg::REG_PRIO4)) begin
         prio4_q <= wdata_in & ipcb_pkg::MASK_PRIO4;
      end
   end

   // Read data valid only in the cycle after the strobe; zero otherwise
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 16'h0000;
      end else if (rd_in) begin
         unique case (addr_in)
            ipcb_pkg::REG_PRIO0: rdata_q <= prio0_q;
            ipcb_pkg::REG_PRIO1: rdata_q <= prio1_q;
            ipcb_pkg::REG_PRIO2: rdata_q <= prio2_q;
            ipcb_pkg::REG_PRIO3: rdata_q <= prio3_q;
            ipcb_pkg::REG_PRIO4: rdata_q <= prio4_q;
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end
   assign rdata_out = rdata_q;

   // Field placement; level is the plain binary value of each field
   assign timer1_prio_out = prio0_q[ipcb_pkg::FLD_HI +: 3];
   assign outcmp1_prio_out = prio0_q[ipcb_pkg::FLD_MH +: 3];
   assign incap1_prio_out = prio0_q[ipcb_pkg::FLD_ML +: 3];
   assign ext_irq0_prio_out = prio0_q[ipcb_pkg::FLD_LO +: 3];
   assign timer2_prio_out = prio1_q[ipcb_pkg::FLD_HI +: 3];
   assign outcmp2_prio_out = prio1_q[ipcb_pkg::FLD_MH +: 3];
   assign incap2_prio_out = prio1_q[ipcb_pkg::FLD_ML +: 3];
   assign dmach0_done_prio_out = prio1_q[ipcb_pkg::FLD_LO +: 3];
   assign uart1_rx_prio_out = prio2_q[ipcb_pkg::FLD_HI +: 3];
   assign spi1_event_prio_out = prio2_q[ipcb_pkg::FLD_MH +: 3];
   assign spi1_error_prio_out = prio2_q[ipcb_pkg::FLD_ML +: 3];
   assign timer3_prio_out = prio2_q[ipcb_pkg::FLD_LO +: 3];
   assign dmach1_done_prio_out = prio3_q[ipcb_pkg::FLD_MH +: 3];
   assign adc1_done_prio_out = prio3_q[ipcb_pkg::FLD_ML +: 3];
   assign uart1_tx_prio_out = prio3_q[ipcb_pkg::FLD_LO +: 3];
   assign change_notify_prio_out = prio4_q[ipcb_pkg::FLD_HI +: 3];
   assign i2c1_master_prio_out = prio4_q[ipcb_pkg::FLD_ML +: 3];
   assign i2c1_slave_prio_out = prio4_q[ipcb_pkg::FLD_LO +: 3];

   // Source order for request bits 0..17 follows the output list above
   assign prio_vec = {i2c1_slave_prio_out, i2c1_master_prio_out, change_notify_prio_out,
      uart1_tx_prio_out, adc1_done_prio_out, dmach1_done_prio_out,
      timer3_prio_out, spi1_error_prio_out, spi1_event_prio_out, uart1_rx_prio_out,
      dmach0_done_prio_out, incap2_prio_out, outcmp2_prio_out, timer2_prio_out,
      ext_irq0_prio_out, incap1_prio_out, outcmp1_prio_out, timer1_prio_out};

   ipcb_gate #(.N(ipcb_pkg::NUM_SRC)) u_gate (
      .flag_in(flag_in),
      .prio_in(prio_vec),
      .req_out(req_out)
   );

   // Nonzero level per source, in request-bit order; built apart from the gate so a broken compare shows
   logic [ipcb_pkg::NUM_SRC-1:0] level_on;
   assign level_on = {|i2c1_slave_prio_out, |i2c1_master_prio_out, |change_notify_prio_out,
      |uart1_tx_prio_out, |adc1_done_prio_out, |dmach1_done_prio_out,
      |timer3_prio_out, |spi1_error_prio_out, |spi1_event_prio_out, |uart1_rx_prio_out,
      |dmach0_done_prio_out, |incap2_prio_out, |outcmp2_prio_out, |timer2_prio_out,
      |ext_irq0_prio_out, |incap1_prio_out, |outcmp1_prio_out, |timer1_prio_out};

   // Request gating
   a_disabled_no_req: assert property (@(posedge clock_in) disable iff (rst_in)
      (timer1_prio_out == ipcb_pkg::PRIO_OFF) |-> !req_out[0])
      else $error("request raised for disabled source");
   a_off_dmach0: assert property (@(posedge clock_in) disable iff (rst_in)
      (dmach0_done_prio_out == ipcb_pkg::PRIO_OFF) |-> !req_out[7])
      else $error("request raised for disabled dma channel 0");
   a_off_timer3: assert property (@(posedge clock_in) disable iff (rst_in)
      (timer3_prio_out == ipcb_pkg::PRIO_OFF) |-> !req_out[11])
      else $error("request raised for disabled timer 3");
   a_off_uart1_tx: assert property (@(posedge clock_in) disable iff (rst_in)
      (uart1_tx_prio_out == ipcb_pkg::PRIO_OFF) |-> !req_out[14])
      else $error("request raised for disabled uart transmit");
   a_off_i2c1_slave: assert property (@(posedge clock_in) disable iff (rst_in)
      (i2c1_slave_prio_out == ipcb_pkg::PRIO_OFF) |-> !req_out[17])
      else $error("request raised for disabled i2c slave");
   a_enabled_req_follows: assert property (@(posedge clock_in) disable iff (rst_in)
      (flag_in[17] && i2c1_slave_prio_out != ipcb_pkg::PRIO_OFF) |-> req_out[17])
      else $error("enabled flagged source not requested");
   a_req_needs_flag: assert property (@(posedge clock_in) disable iff (rst_in)
      ((req_out & ~flag_in) == 18'h00000))
      else $error("request raised without its flag");
   a_req_match: assert property (@(posedge clock_in) disable iff (rst_in)
      (req_out == (flag_in & level_on)))
      else $error("request vector differs from flags and levels");

   // Reset defaults; checked at the first edge that sees reset released
   a_reset_default: assert property (@(posedge clock_in)
      $fell(rst_in) |-> (uart1_rx_prio_out == ipcb_pkg::PRIO_RESET && dmach1_done_prio_out == 3'h4))
      else $error("reset default not four");
   a_reset_prio0: assert property (@(posedge clock_in)
      $fell(rst_in) |-> (prio0_q == ipcb_pkg::RST_FULL))
      else $error("register zero not at reset value");
   a_reset_prio1: assert property (@(posedge clock_in)
      $fell(rst_in) |-> (prio1_q == ipcb_pkg::RST_FULL))
      else $error("register one not at reset value");
   a_reset_prio2: assert property (@(posedge clock_in)
      $fell(rst_in) |-> (prio2_q == ipcb_pkg::RST_FULL))
      else $error("register two not at reset value");
   a_reset_prio3: assert property (@(posedge clock_in)
      $fell(rst_in) |-> (prio3_q == ipcb_pkg::RST_PRIO3))
      else $error("register three not at reset value");
   a_reset_prio4: assert property (@(posedge clock_in)
      $fell(rst_in) |-> (prio4_q == ipcb_pkg::RST_PRIO4))
      else $error("register four not at reset value");

   // Reserved bits never hold a one, whatever software writes
   a_reserved_prio0: assert property (@(posedge clock_in) disable iff (rst_in)
      ((prio0_q & ~ipcb_pkg::MASK_FULL) == 16'h0000))
      else $error("reserved bits set in register zero");
   a_reserved_prio1: assert property (@(posedge clock_in) disable iff (rst_in)
      ((prio1_q & ~ipcb_pkg::MASK_FULL) == 16'h0000))
      else $error("reserved bits set in register one");
   a_reserved_prio2: assert property (@(posedge clock_in) disable iff (rst_in)
      ((prio2_q & ~ipcb_pkg::MASK_FULL) == 16'h0000))
      else $error("reserved bits set in register two");
   a_reserved_prio3: assert property (@(posedge clock_in) disable iff (rst_in)
      ((prio3_q & ~ipcb_pkg::MASK_PRIO3) == 16'h0000))
      else $error("reserved bits set in register three");
   a_reserved_prio4: assert property (@(posedge clock_in) disable iff (rst_in)
      ((prio4_q & ~ipcb_pkg::MASK_PRIO4) == 16'h0000))
      else $error("reserved bits set in register four");

   // Writes and field placement
   a_write_takes: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in == ipcb_pkg::REG_PRIO0) |=> (timer1_prio_out == $past(wdata_in[14:12])))
      else $error("write did not set priority");
   a_write_readback: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in == ipcb_pkg::REG_PRIO1) ##1 (rd_in && addr_in == ipcb_pkg::REG_PRIO1 && !wr_in)
      |=> (rdata_out == ($past(wdata_in, 2) & ipcb_pkg::MASK_FULL)))
      else $error("readback mismatch");
   a_place_prio0: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in == ipcb_pkg::REG_PRIO0) |=> (timer1_prio_out == $past(wdata_in[14:12])
      && outcmp1_prio_out == $past(wdata_in[10:8]) && incap1_prio_out == $past(wdata_in[6:4])
      && ext_irq0_prio_out == $past(wdata_in[2:0])))
      else $error("register zero placement wrong");
   a_place_prio1: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in == ipcb_pkg::REG_PRIO1) |=> (timer2_prio_out == $past(wdata_in[14:12])
      && outcmp2_prio_out == $past(wdata_in[10:8]) && incap2_prio_out == $past(wdata_in[6:4])
      && dmach0_done_prio_out == $past(wdata_in[2:0])))
      else $error("register one placement wrong");
   a_place_prio2: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in == ipcb_pkg::REG_PRIO2) |=> (uart1_rx_prio_out == $past(wdata_in[14:12])
      && spi1_event_prio_out == $past(wdata_in[10:8]) && spi1_error_prio_out == $past(wdata_in[6:4])
      && timer3_prio_out == $past(wdata_in[2:0])))
      else $error("field placement wrong");
   a_place_prio3: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in == ipcb_pkg::REG_PRIO3) |=> (dmach1_done_prio_out == $past(wdata_in[10:8])
      && adc1_done_prio_out == $past(wdata_in[6:4]) && uart1_tx_prio_out == $past(wdata_in[2:0])))
      else $error("register three placement wrong");
   a_place_prio4: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr_in && addr_in == ipcb_pkg::REG_PRIO4) |=> (change_notify_prio_out == $past(wdata_in[14:12])
      && i2c1_master_prio_out == $past(wdata_in[6:4]) && i2c1_slave_prio_out == $past(wdata_in[2:0])))
      else $error("register four placement wrong");

   // A level only moves on a write to its own register
   a_hold_prio0: assert property (@(posedge clock_in) disable iff (rst_in)
      !(wr_in && addr_in == ipcb_pkg::REG_PRIO0) |=> $stable(prio0_q))
      else $error("register zero changed without a write");
   a_hold_prio1: assert property (@(posedge clock_in) disable iff (rst_in)
      !(wr_in && addr_in == ipcb_pkg::REG_PRIO1) |=> $stable(prio1_q))
      else $error("register one changed without a write");
   a_hold_prio2: assert property (@(posedge clock_in) disable iff (rst_in)
      !(wr_in && addr_in == ipcb_pkg::REG_PRIO2) |=> $stable(prio2_q))
      else $error("register two changed without a write");
   a_hold_prio3: assert property (@(posedge clock_in) disable iff (rst_in)
      !(wr_in && addr_in == ipcb_pkg::REG_PRIO3) |=> $stable(prio3_q))
      else $error("register three changed without a write");
   a_hold_prio4: assert property (@(posedge clock_in) disable iff (rst_in)
      !(wr_in && addr_in == ipcb_pkg::REG_PRIO4) |=> $stable(prio4_q))
      else $error("register four changed without a write");

   // Read path: data stand only in the cycle after the strobe
   a_unused_read_zero: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == ipcb_pkg::REG_PRIO3) |=> (rdata_out[15:11] == 5'h00))
      else $error("unimplemented bits read nonzero");
   a_read_masked: assert property (@(posedge clock_in) disable iff (rst_in)
      rd_in |=> ((rdata_out & ~reg_mask($past(addr_in))) == 16'h0000))
      else $error("reserved bit read nonzero");
   a_read_prio0: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == ipcb_pkg::REG_PRIO0) |=> (rdata_out == $past(prio0_q)))
      else $error("register zero read wrong");
   a_read_prio1: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == ipcb_pkg::REG_PRIO1) |=> (rdata_out == $past(prio1_q)))
      else $error("register one read wrong");
   a_read_prio2: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == ipcb_pkg::REG_PRIO2) |=> (rdata_out == $past(prio2_q)))
      else $error("register two read wrong");
   a_read_prio3: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == ipcb_pkg::REG_PRIO3) |=> (rdata_out == $past(prio3_q)))
      else $error("register three read wrong");
   a_read_prio4: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == ipcb_pkg::REG_PRIO4) |=> (rdata_out == $past(prio4_q)))
      else $error("register four read wrong");
   a_read_unmapped: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in > ipcb_pkg::REG_PRIO4) |=> (rdata_out == 16'h0000))
      else $error("unmapped index read nonzero");
   a_read_idle_zero: assert property (@(posedge clock_in) disable iff (rst_in)
      !rd_in |=> (rdata_out == 16'h0000))
      else $error("read data present without a read");
endmodule
`default_nettype wire

// [bench/test_interrupt_priority_config_bank.sv]
// Self-checking bench for the interrupt priority bank
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_priority_config_bank;
   localparam int RIX[18] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4};
   localparam int LSB[18] = '{12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 12, 4, 0};
   localparam logic [15:0] MASK[5] = '{16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7077};
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [17:0] flag_in = 18'h00000;
   wire logic [15:0] rdata_out;
   wire logic [17:0] req_out;
   wire logic [53:0] pv;
   logic [15:0] model[5];
   logic [15:0] exp_q[$];
   logic rd_p = 1'b0;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;

   ipcb_bank dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .flag_in(flag_in), .req_out(req_out),
      .timer1_prio_out(pv[2:0]), .outcmp1_prio_out(pv[5:3]), .incap1_prio_out(pv[8:6]),
      .ext_irq0_prio_out(pv[11:9]), .timer2_prio_out(pv[14:12]), .outcmp2_prio_out(pv[17:15]),
      .incap2_prio_out(pv[20:18]), .dmach0_done_prio_out(pv[23:21]), .uart1_rx_prio_out(pv[26:24]),
      .spi1_event_prio_out(pv[29:27]), .spi1_error_prio_out(pv[32:30]), .timer3_prio_out(pv[35:33]),
      .dmach1_done_prio_out(pv[38:36]), .adc1_done_prio_out(pv[41:39]), .uart1_tx_prio_out(pv[44:42]),
      .change_notify_prio_out(pv[47:45]), .i2c1_master_prio_out(pv[50:48]), .i2c1_slave_prio_out(pv[53:51]));

   always #5 clock_in = ~clock_in;

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Model is updated at issue; the bank makes it visible one edge later
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      rd_in <= 1'b0;
      if (a < 4'h5) model[a] = d & MASK[a];
   endtask

   task rd(input logic [3:0] a);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      wr_in <= 1'b0;
      exp_q.push_back(a < 4'h5 ? model[a] : 16'h0000);
   endtask

   task idle;
      @(posedge clock_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
   endtask

   task check_fields;
      int i;
      logic [2:0] f;
      @(negedge clock_in);
      for (i = 0; i < 18; i++) begin
         f = model[RIX[i]][LSB[i] +: 3];
         check("prio field", {13'h0000, f}, {13'h0000, pv[3*i +: 3]});
         check("request", {15'h0000, flag_in[i] && f != 3'h0}, {15'h0000, req_out[i]});
      end
   endtask

   task reset_model;
      int i;
      for (i = 0; i < 5; i++) model[i] = 16'h4444 & MASK[i];
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clock_in) rd_p <= rd_in;
   always @(negedge clock_in) begin
      if (rd_p) check("read data", exp_q.pop_front(), rdata_out);
   end

   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         end_sim;
      end
   end

   initial begin
      int i;
      int v;
      reset_model;
      void'($urandom(46450));
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      for (i = 0; i < 16; i++) rd(i[3:0]);
      idle;
      check_fields;
      $display("test reset values done");
      for (i = 0; i < 16; i++) wr(i[3:0], 16'hFFFF);
      for (i = 0; i < 5; i++) rd(i[3:0]);
      idle;
      check_fields;
      $display("test unused bits done");
      wr(4'h0, 16'h7123);
      wr(4'h1, 16'h2A5C);
      rd(4'h1);
      idle;
      check_fields;
      check("walk fields", {4'h0, 3'h3, 3'h2, 3'h1, 3'h7}, {4'h0, pv[11:0]});
      $display("test field map done");
      for (v = 0; v < 8; v++) begin
         wr(4'h0, 16'h1111 * v[15:0]);
         flag_in <= 18'h3FFFF;
         idle;
         check_fields;
      end
      $display("test levels done");
      for (i = 0; i < 40; i++) begin
         wr(4'($urandom_range(4, 0)), 16'($urandom));
         flag_in <= 18'($urandom);
         rd(4'($urandom_range(15, 0)));
         idle;
         check_fields;
      end
      $display("test random access done");
      @(posedge clock_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      reset_model;
      for (i = 0; i < 5; i++) rd(i[3:0]);
      idle;
      check_fields;
      $display("test second reset done");
      repeat (2) @(posedge clock_in);
      end_sim;
   end
endmodule
`default_nettype wire
